// File: hw/iefb_pkg.sv
// constants shared by the interrupt enable and flag bank
package iefb_pkg;
  // register byte offsets, one aligned word each
  localparam logic [5:0] OFS_EDGE_SEL   = 6'h00;
  localparam logic [5:0] OFS_PRIMARY_0  = 6'h04;
  localparam logic [5:0] OFS_PRIMARY_1  = 6'h08;
  localparam logic [5:0] OFS_PRIMARY_2  = 6'h0c;
  localparam logic [5:0] OFS_PRIMARY_3  = 6'h10;
  localparam logic [5:0] OFS_GROUP_0    = 6'h14;
  localparam logic [5:0] OFS_GROUP_1    = 6'h18;
  localparam logic [5:0] OFS_GROUP_2    = 6'h1c;
  localparam logic [5:0] OFS_GROUP_3    = 6'h20;
  localparam logic [5:0] OFS_EVT_STATUS = 6'h24;
  localparam logic [5:0] OFS_EVT_MASK   = 6'h28;

  // writable bits per register; the rest read as zero
  localparam logic [7:0] MASK_EDGE_SEL  = 8'h0f;
  localparam logic [7:0] MASK_PRIMARY_0 = 8'h7f;
  localparam logic [7:0] MASK_FULL      = 8'hff;
  localparam logic [7:0] MASK_GROUP_0   = 8'h77;
  localparam logic [7:0] MASK_GROUP_2   = 8'h77;
  localparam logic [2:0] MASK_EVT       = 3'h7;

  // field positions
  localparam int POS_PIN0_SEL   = 0;
  localparam int POS_PIN1_SEL   = 2;
  localparam int POS_GLOBAL_EN  = 0;
  localparam int POS_PIN0_FLAG  = 4;
  localparam int POS_PIN1_FLAG  = 5;
  localparam int POS_TOUCH_FLAG = 6;
  localparam int POS_EVT_VECTOR = 0;
  localparam int POS_EVT_WAKE   = 1;
  localparam int POS_EVT_PIN    = 2;

  // reset values
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [2:0] RST_EVT  = 3'h0;

  // number of primary vectors
  localparam int NUM_VEC = 15;

  typedef enum logic [1:0] {
    IEFB_EDGE_OFF  = 2'h0,
    IEFB_EDGE_RISE = 2'h1,
    IEFB_EDGE_FALL = 2'h2,
    IEFB_EDGE_BOTH = 2'h3
  } iefb_edge_t;
endpackage

// File: hw/iefb_bank.sv
// interrupt request flag and enable bank with avalon-mm register access
// What this block does
// [R1] edge field: 00 off, 01 rising, 10 falling, 11 both edges
// [R2] edge register: pin 1 field bits 3:2, pin 0 field bits 1:0
// [R3] unimplemented bits of edge and control registers read zero
// [R4] primary register 0 bit 0 is the global interrupt enable
// [R5] primary 0: touch, pin1, pin0 flags bits 6:4; enables bits 3:1
// [R6] primary 1: two-wire, uart2..0 flags bits 7:4; enables bits 3:0
// [R7] primary 2: group2, converter, group1, group0 flags 7:4; enables 3:0
// [R8] primary 3: group4, tick1, tick0, group3 flags 7:4; enables 3:0
// [R9] group 0: overvolt, timer0 a/p flags 6:4; enables 2:0; 7,3 unused
// [R10] group 1: standard a/p, compact1 a/p flags 7:4; enables 3:0
// [R11] group 2: serial module, periodic0 a/p flags 6:4; enables 2:0
// [R12] group 3: periodic2 a/p, periodic1 a/p flags 7:4; enables 3:0
// [R13] software clears group sub-flags; hardware never clears them
// [R14] group 0-3 flag sets when any enabled sub-flag in its register is set; group 4 flag from group4_req
// [R15] event in the same cycle as a clearing write keeps the flag set
// [R16] vector only when flag, its enable and global enable are all one
// [R17] service entry clears global enable; new flags still recorded
// [R18] servicing a pin interrupt clears that pin flag
// [R19] any flag becoming set by a hardware event wakes the device
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ps
module iefb_bank #(
  parameter int ADDR_W = 6
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // external pins, synchronous
  input  wire logic [1:0]  pin_in,
  // peripheral request pulses
  input  wire logic        touch_evt,
  input  wire logic [2:0]  uart_evt,
  input  wire logic        twowire_evt,
  input  wire logic        converter_evt,
  input  wire logic [1:0]  tick_evt,
  input  wire logic        group4_req,
  input  wire logic        overvolt_evt,
  input  wire logic [1:0]  compact_timer_a_evt,
  input  wire logic [1:0]  compact_timer_p_evt,
  input  wire logic        standard_timer_a_evt,
  input  wire logic        standard_timer_p_evt,
  input  wire logic [2:0]  periodic_timer_a_evt,
  input  wire logic [2:0]  periodic_timer_p_evt,
  input  wire logic        serial_module_evt,
  // core vectoring
  input  wire logic        svc_ack,
  output logic             vec_valid,
  output logic [3:0]       vec_id,
  output logic             wake,
  // interrupt to the system
  output logic             irq
);

  if (ADDR_W < 6) begin : g_chk
    $error("ADDR_W must be at least 6");
  end

  logic [7:0] edge_sel;
  logic [7:0] prim0;
  logic [7:0] prim1;
  logic [7:0] prim2;
  logic [7:0] prim3;
  logic [7:0] grp0;
  logic [7:0] grp1;
  logic [7:0] grp2;
  logic [7:0] grp3;
  logic [2:0] evt_status;
  logic [2:0] evt_mask;
  logic [1:0] pin_prev;
  logic       bus_ack;
  logic       wr_go;
  logic [5:0] ofs;
  logic [1:0] pin_evt;
  logic [4:0] grp_cond;
  logic [14:0] prim_flags;
  logic [14:0] prim_ens;
  logic [14:0] prim_live;
  logic [14:0] svc_hot;
  logic [3:0]  next_vec_id;
  logic        next_vec_valid;
  logic [7:0]  next_rd;

  // masked write or hold-and-clear, with hardware sets always on top
  function automatic logic [7:0] upd8(input logic [7:0] cur, input logic wr,
                                      input logic [7:0] wd, input logic [7:0] set,
                                      input logic [7:0] clr, input logic [7:0] msk);
    upd8 = ((wr ? wd : (cur & ~clr)) | set) & msk; // [R15] [R3]
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic now,
                                    input logic prev);
    logic rise;
    logic fall;
    rise = now & ~prev;
    fall = ~now & prev;
    unique case (iefb_pkg::iefb_edge_t'(sel)) // [R1]
      iefb_pkg::IEFB_EDGE_OFF:  edge_hit = 1'b0;
      iefb_pkg::IEFB_EDGE_RISE: edge_hit = rise;
      iefb_pkg::IEFB_EDGE_FALL: edge_hit = fall;
      iefb_pkg::IEFB_EDGE_BOTH: edge_hit = rise | fall;
    endcase
  endfunction

  function automatic logic is_wr(input logic go, input logic [5:0] a,
                                 input logic [5:0] o);
    is_wr = go & (a == o);
  endfunction

  // bus: one wait cycle so read data comes from a flop
  assign ofs             = avs_address[5:0];
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
  assign wr_go           = avs_write & bus_ack;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read | avs_write) & ~bus_ack;
    end
  end

  always_comb begin
    unique case (ofs)
      iefb_pkg::OFS_EDGE_SEL:   next_rd = edge_sel;
      iefb_pkg::OFS_PRIMARY_0:  next_rd = prim0;
      iefb_pkg::OFS_PRIMARY_1:  next_rd = prim1;
      iefb_pkg::OFS_PRIMARY_2:  next_rd = prim2;
      iefb_pkg::OFS_PRIMARY_3:  next_rd = prim3;
      iefb_pkg::OFS_GROUP_0:    next_rd = grp0;
      iefb_pkg::OFS_GROUP_1:    next_rd = grp1;
      iefb_pkg::OFS_GROUP_2:    next_rd = grp2;
      iefb_pkg::OFS_GROUP_3:    next_rd = grp3;
      iefb_pkg::OFS_EVT_STATUS: next_rd = {5'h00, evt_status};
      iefb_pkg::OFS_EVT_MASK:   next_rd = {5'h00, evt_mask};
      default:                  next_rd = 8'h00; // unmapped reads zero
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !bus_ack) begin
      avs_readdata <= {24'h00_0000, next_rd};
    end
  end

  // pin edge detection; pins are synchronous to sys_clk
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev <= 2'h0;
    end else begin
      pin_prev <= pin_in;
    end
  end

  assign pin_evt[0] = edge_hit(edge_sel[iefb_pkg::POS_PIN0_SEL +: 2], pin_in[0],
                               pin_prev[0]); // [R2]
  assign pin_evt[1] = edge_hit(edge_sel[iefb_pkg::POS_PIN1_SEL +: 2], pin_in[1],
                               pin_prev[1]); // [R2]

  // group 0-3 request is the or of enabled sub-flags; group 4 request is group4_req
  assign grp_cond[0] = |(grp0[7:4] & grp0[3:0]); // [R14]
  assign grp_cond[1] = |(grp1[7:4] & grp1[3:0]); // [R14]
  assign grp_cond[2] = |(grp2[7:4] & grp2[3:0]); // [R14]
  assign grp_cond[3] = |(grp3[7:4] & grp3[3:0]); // [R14]
  assign grp_cond[4] = group4_req;

  // vector index order, lowest index wins on simultaneous requests
  assign prim_flags = {prim3[7], prim3[6], prim3[5], prim3[4], prim2[7], prim2[6],
                       prim2[5], prim2[4], prim1[7], prim1[6], prim1[5], prim1[4],
                       prim0[6], prim0[5], prim0[4]};
  assign prim_ens   = {prim3[3], prim3[2], prim3[1], prim3[0], prim2[3], prim2[2],
                       prim2[1], prim2[0], prim1[3], prim1[2], prim1[1], prim1[0],
                       prim0[3], prim0[2], prim0[1]};
  // live requests as a net, so the vector check can look one cycle back
  assign prim_live  = prim_flags & prim_ens;

  always_comb begin
    next_vec_id    = 4'h0;
    next_vec_valid = 1'b0;
    for (int i = iefb_pkg::NUM_VEC - 1; i >= 0; i--) begin
      if (prim_flags[i] && prim_ens[i]) begin
        next_vec_id    = 4'(i);
        next_vec_valid = prim0[iefb_pkg::POS_GLOBAL_EN]; // [R16] [R4]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_valid <= 1'b0;
      vec_id    <= 4'h0;
    end else begin
      vec_valid <= next_vec_valid & ~svc_ack;
      vec_id    <= next_vec_id;
    end
  end

  // primary flags auto-clear on service
  assign svc_hot = (svc_ack && vec_valid) ? (15'h0001 << vec_id) : 15'h0000; // [R18]

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_sel <= iefb_pkg::RST_REG8;
    end else begin
      edge_sel <= upd8(edge_sel, is_wr(wr_go, ofs, iefb_pkg::OFS_EDGE_SEL),
                       avs_writedata[7:0], 8'h00, 8'h00, iefb_pkg::MASK_EDGE_SEL);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prim0 <= iefb_pkg::RST_REG8;
      prim1 <= iefb_pkg::RST_REG8;
      prim2 <= iefb_pkg::RST_REG8;
      prim3 <= iefb_pkg::RST_REG8;
    end else begin
      // service entry drops the global enable; flags keep latching
      prim0 <= upd8(prim0, is_wr(wr_go, ofs, iefb_pkg::OFS_PRIMARY_0),
                    avs_writedata[7:0], {1'b0, touch_evt, pin_evt, 4'h0},
                    {1'b0, svc_hot[2:0], 3'h0, svc_ack & vec_valid},
                    iefb_pkg::MASK_PRIMARY_0); // [R5] [R17] [R18]
      prim1 <= upd8(prim1, is_wr(wr_go, ofs, iefb_pkg::OFS_PRIMARY_1),
                    avs_writedata[7:0], {twowire_evt, uart_evt, 4'h0},
                    {svc_hot[6:3], 4'h0}, iefb_pkg::MASK_FULL); // [R6]
      prim2 <= upd8(prim2, is_wr(wr_go, ofs, iefb_pkg::OFS_PRIMARY_2),
                    avs_writedata[7:0],
                    {grp_cond[2], converter_evt, grp_cond[1], grp_cond[0], 4'h0},
                    {svc_hot[10:7], 4'h0}, iefb_pkg::MASK_FULL); // [R7]
      prim3 <= upd8(prim3, is_wr(wr_go, ofs, iefb_pkg::OFS_PRIMARY_3),
                    avs_writedata[7:0],
                    {grp_cond[4], tick_evt[1], tick_evt[0], grp_cond[3], 4'h0},
                    {svc_hot[14:11], 4'h0}, iefb_pkg::MASK_FULL); // [R8]
    end
  end

  // sub-flags are never cleared by service, only by software
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      grp0 <= iefb_pkg::RST_REG8;
      grp1 <= iefb_pkg::RST_REG8;
      grp2 <= iefb_pkg::RST_REG8;
      grp3 <= iefb_pkg::RST_REG8;
    end else begin
      grp0 <= upd8(grp0, is_wr(wr_go, ofs, iefb_pkg::OFS_GROUP_0), avs_writedata[7:0],
                   {1'b0, overvolt_evt, compact_timer_a_evt[0], compact_timer_p_evt[0],
                    4'h0}, 8'h00, iefb_pkg::MASK_GROUP_0); // [R9] [R13]
      grp1 <= upd8(grp1, is_wr(wr_go, ofs, iefb_pkg::OFS_GROUP_1), avs_writedata[7:0],
                   {standard_timer_a_evt, standard_timer_p_evt, compact_timer_a_evt[1],
                    compact_timer_p_evt[1], 4'h0}, 8'h00, iefb_pkg::MASK_FULL); // [R10]
      grp2 <= upd8(grp2, is_wr(wr_go, ofs, iefb_pkg::OFS_GROUP_2), avs_writedata[7:0],
                   {1'b0, serial_module_evt, periodic_timer_a_evt[0],
                    periodic_timer_p_evt[0], 4'h0}, 8'h00,
                   iefb_pkg::MASK_GROUP_2); // [R11]
      grp3 <= upd8(grp3, is_wr(wr_go, ofs, iefb_pkg::OFS_GROUP_3), avs_writedata[7:0],
                   {periodic_timer_a_evt[2], periodic_timer_p_evt[2],
                    periodic_timer_a_evt[1], periodic_timer_p_evt[1], 4'h0}, 8'h00,
                   iefb_pkg::MASK_FULL); // [R12]
    end
  end

  // wake on any flag going from clear to set by hardware
  logic [63:0] all_cur;
  logic [63:0] all_set;
  assign all_cur = {prim0, prim1, prim2, prim3, grp0, grp1, grp2, grp3};
  assign all_set = {1'b0, touch_evt, pin_evt, 4'h0, twowire_evt, uart_evt, 4'h0,
                    grp_cond[2], converter_evt, grp_cond[1], grp_cond[0], 4'h0,
                    grp_cond[4], tick_evt, grp_cond[3], 4'h0,
                    1'b0, overvolt_evt, compact_timer_a_evt[0], compact_timer_p_evt[0],
                    4'h0, standard_timer_a_evt, standard_timer_p_evt,
                    compact_timer_a_evt[1], compact_timer_p_evt[1], 4'h0,
                    1'b0, serial_module_evt, periodic_timer_a_evt[0],
                    periodic_timer_p_evt[0], 4'h0, periodic_timer_a_evt[2],
                    periodic_timer_p_evt[2], periodic_timer_a_evt[1],
                    periodic_timer_p_evt[1], 4'h0};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake <= 1'b0;
    end else begin
      wake <= |(all_set & ~all_cur); // [R19]
    end
  end

  // block status events, write one to clear, set wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_status <= iefb_pkg::RST_EVT;
      evt_mask   <= iefb_pkg::RST_EVT;
    end else begin
      evt_status <= (evt_status & ~(is_wr(wr_go, ofs, iefb_pkg::OFS_EVT_STATUS) ?
                                    avs_writedata[2:0] : 3'h0))
                    | {|pin_evt, |(all_set & ~all_cur), svc_ack & vec_valid};
      if (is_wr(wr_go, ofs, iefb_pkg::OFS_EVT_MASK)) begin
        evt_mask <= avs_writedata[2:0] & iefb_pkg::MASK_EVT;
      end
    end
  end

  assign irq = |(evt_status & evt_mask);

  // ---- assertions ----
  sequence s_rd_req;
    avs_read && !bus_ack;
  endsequence

  sequence s_rd_done;
    avs_read && !avs_waitrequest;
  endsequence

  a_read_one_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_rd_req |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait cycle");

  a_group0_unused: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
    s_rd_req ##0 (ofs == iefb_pkg::OFS_GROUP_0) ##1 s_rd_done
    |-> (avs_readdata[7] == 1'b0) && (avs_readdata[3] == 1'b0))
    else $error("unused group bits read nonzero");

  a_edge_upper_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
    s_rd_req ##0 (ofs == iefb_pkg::OFS_EDGE_SEL) ##1 s_rd_done
    |-> avs_readdata[7:4] == 4'h0)
    else $error("edge select upper bits read nonzero");

  a_pin_rise_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
    (edge_sel[1:0] == 2'h1 && pin_in[0] && !pin_prev[0]) |=> prim0[4])
    else $error("rising edge did not set pin 0 flag");

  a_pin1_fall_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
    (edge_sel[3:2] == 2'h2 && !pin_in[1] && pin_prev[1]) |=> prim0[5])
    else $error("falling edge did not set pin 1 flag");

  a_set_wins_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R15]
    (touch_evt && wr_go && ofs == iefb_pkg::OFS_PRIMARY_0 && !avs_writedata[6])
    |=> prim0[6])
    else $error("event lost against clearing write");

  a_group_raise: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R14]
    (grp0[6] && grp0[2]) |=> prim2[4])
    else $error("enabled sub-flag did not raise group 0 flag");

  a_sub_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R13]
    (grp3[7] && !(wr_go && ofs == iefb_pkg::OFS_GROUP_3)) |=> grp3[7])
    else $error("sub-flag cleared without software");

  // today's id picks from last cycle's requests, as the id flop does
  a_vec_gated: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R16]
    vec_valid |-> $past(prim0[0]) &&
                  ((($past(prim_live) >> vec_id) & 15'h0001) != 15'h0000))
    else $error("vector offered without enables");

  a_svc_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R17]
    (svc_ack && vec_valid && !wr_go) |=> !prim0[0] ##1 !vec_valid)
    else $error("service entry did not block nesting");

  a_pin_autoclr: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R18]
    (svc_ack && vec_valid && vec_id == 4'h0 && !wr_go && !pin_evt[0]) |=> !prim0[4])
    else $error("pin 0 flag not cleared on service");

  a_wake_on_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R19]
    ($rose(prim1[7]) && !$past(wr_go)) |-> wake)
    else $error("flag set without wake");

endmodule

// File: sim/iefb_core_model.sv
// core model that takes offered vectors after a bench-set delay
`timescale 1ns/1ps
module iefb_core_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // vector offer
  input  wire logic       vec_valid,
  input  wire logic [3:0] vec_id,
  // bench control
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_dly,
  // acknowledge and record
  output logic            svc_ack,
  output logic [3:0]      taken_id,
  output logic [7:0]      taken_cnt
);
  logic [3:0] wait_cnt;
  // one pulse per entry; a dropped offer restarts the delay
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      svc_ack   <= 1'b0;
      wait_cnt  <= 4'h0;
      taken_id  <= 4'h0;
      taken_cnt <= 8'h00;
    end else if (svc_ack) begin
      svc_ack  <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (vec_valid && ack_en) begin
      if (wait_cnt >= ack_dly) begin
        svc_ack   <= 1'b1;
        taken_id  <= vec_id;
        taken_cnt <= taken_cnt + 8'h01;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end else begin
      wait_cnt <= 4'h0;
    end
  end
endmodule

// File: sim/tb_interrupt_enable_flag_bank.sv
// self-checking bench for the interrupt enable and flag bank
`timescale 1ns/1ps
module tb_interrupt_enable_flag_bank;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  pin_in = 2'h0;
  // event bits: 0 touch, 3:1 uart, 4 twowire, 5 converter, 7:6 tick, 8 group4,
  // 9 overvolt, 11:10 compact a, 13:12 compact p, 14/15 standard a/p,
  // 18:16 periodic a, 21:19 periodic p, 22 serial module
  logic [22:0] evt = 23'h0;
  logic        svc_ack;
  logic        vec_valid;
  logic [3:0]  vec_id;
  logic        wake;
  logic        irq;
  logic        ack_en = 1'b0;
  logic [3:0]  ack_dly = 4'h0;
  logic [3:0]  taken_id;
  logic [7:0]  taken_cnt;
  logic [15:0] n_wake = 16'h0;
  logic [31:0] q;
  int          n_fail = 0;
  int          checked = 0;

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (wake === 1'b1) n_wake <= n_wake + 16'h1;

  iefb_bank dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .touch_evt(evt[0]),
    .uart_evt(evt[3:1]), .twowire_evt(evt[4]), .converter_evt(evt[5]),
    .tick_evt(evt[7:6]), .group4_req(evt[8]), .overvolt_evt(evt[9]),
    .compact_timer_a_evt(evt[11:10]), .compact_timer_p_evt(evt[13:12]),
    .standard_timer_a_evt(evt[14]), .standard_timer_p_evt(evt[15]),
    .periodic_timer_a_evt(evt[18:16]), .periodic_timer_p_evt(evt[21:19]),
    .serial_module_evt(evt[22]), .svc_ack(svc_ack), .vec_valid(vec_valid),
    .vec_id(vec_id), .wake(wake), .irq(irq));
  iefb_core_model core_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .vec_valid(vec_valid), .vec_id(vec_id),
    .ack_en(ack_en), .ack_dly(ack_dly), .svc_ack(svc_ack), .taken_id(taken_id),
    .taken_cnt(taken_cnt));

  task automatic end_of_test();
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 16);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 16) begin
      n_fail++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask
  task automatic pulse(input logic [22:0] m);
    @(posedge sys_clk);
    evt <= m;
    @(posedge sys_clk);
    evt <= 23'h0;
  endtask
  task automatic wait_ack(input logic [7:0] c0);
    int n;
    for (n = 0; n < 50 && taken_cnt === c0; n++) @(posedge sys_clk);
    if (n >= 50) begin
      n_fail++;
      end_of_test();
    end
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic t_reset();
    logic [5:0] ofs[5] = '{iefb_pkg::OFS_EDGE_SEL, iefb_pkg::OFS_PRIMARY_0,
      iefb_pkg::OFS_GROUP_0, iefb_pkg::OFS_GROUP_2, iefb_pkg::OFS_PRIMARY_1};
    logic [7:0] msk[5] = '{8'h0f, 8'h7f, 8'h77, 8'h77, 8'hff};
    for (int a = 0; a <= 6'h2c; a += 4) rd(6'(a), 8'h00);
    wr(6'h2c, 8'hff);
    rd(6'h2c, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(ofs[i], 8'hff);
      rd(ofs[i], msk[i]);
      wr(ofs[i], 8'h00);
    end
    wr(iefb_pkg::OFS_PRIMARY_2, 8'h00);
  endtask
  task automatic t_edges();
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        wr(iefb_pkg::OFS_EDGE_SEL, 8'(m << (2 * p)));
        pin_in[p] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(iefb_pkg::OFS_PRIMARY_0, 8'((m & 1) << (4 + p)));
        wr(iefb_pkg::OFS_PRIMARY_0, 8'h00);
        pin_in[p] <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd(iefb_pkg::OFS_PRIMARY_0, 8'((m >> 1) << (4 + p)));
        wr(iefb_pkg::OFS_PRIMARY_0, 8'h00);
      end
    end
  endtask
  task automatic t_vector();
    wr(iefb_pkg::OFS_EDGE_SEL, 8'h01);
    wr(iefb_pkg::OFS_PRIMARY_0, 8'h0a);
    ack_en <= 1'b1;
    ack_dly <= 4'h3;
    pulse(23'h1);
    pin_in[0] <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk({31'h0, vec_valid}, 32'h0);
    rd(iefb_pkg::OFS_PRIMARY_0, 8'h5a);
    wr(iefb_pkg::OFS_PRIMARY_0, 8'h5b);
    wait_ack(taken_cnt);
    chk({28'h0, taken_id}, 32'h0);
    rd(iefb_pkg::OFS_PRIMARY_0, 8'h4a);
    pulse(23'h2);
    rd(iefb_pkg::OFS_PRIMARY_1, 8'h10);
    ack_dly <= 4'h0;
    wr(iefb_pkg::OFS_PRIMARY_0, 8'h4b);
    wait_ack(taken_cnt);
    chk({28'h0, taken_id}, 32'h2);
    rd(iefb_pkg::OFS_PRIMARY_0, 8'h0a);
    ack_en <= 1'b0;
    pin_in[0] <= 1'b0;
    wr(iefb_pkg::OFS_PRIMARY_0, 8'h00);
    wr(iefb_pkg::OFS_PRIMARY_1, 8'h00);
    wr(iefb_pkg::OFS_EDGE_SEL, 8'h00);
  endtask
  task automatic t_status();
    rd(iefb_pkg::OFS_EVT_STATUS, 8'h07);
    wr(iefb_pkg::OFS_EVT_MASK, 8'h01);
    rd(iefb_pkg::OFS_EVT_MASK, 8'h01);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    wr(iefb_pkg::OFS_EVT_STATUS, 8'h07);
    rd(iefb_pkg::OFS_EVT_STATUS, 8'h00);
    chk({31'h0, irq}, 32'h0);
    wr(iefb_pkg::OFS_EVT_MASK, 8'h00);
  endtask
  task automatic t_groups();
    logic [5:0] go[4] = '{iefb_pkg::OFS_GROUP_0, iefb_pkg::OFS_GROUP_1,
      iefb_pkg::OFS_GROUP_2, iefb_pkg::OFS_GROUP_3};
    logic [5:0] po[4] = '{iefb_pkg::OFS_PRIMARY_2, iefb_pkg::OFS_PRIMARY_2,
      iefb_pkg::OFS_PRIMARY_2, iefb_pkg::OFS_PRIMARY_3};
    int ev[4] = '{9, 14, 22, 18};
    logic [7:0] fl[4] = '{8'h40, 8'h80, 8'h40, 8'h80};
    logic [7:0] en[4] = '{8'h04, 8'h08, 8'h04, 8'h08};
    logic [7:0] pb[4] = '{8'h10, 8'h20, 8'h80, 8'h10};
    for (int g = 0; g < 4; g++) begin
      pulse(23'(1) << ev[g]);
      rd(go[g], fl[g]);
      rd(po[g], 8'h00);
      wr(go[g], fl[g] | en[g]);
      rd(po[g], pb[g]);
      wr(po[g], 8'h00);
      rd(go[g], fl[g] | en[g]);
      wr(go[g], 8'h00);
      wr(po[g], 8'h00);
      rd(po[g], 8'h00);
    end
  endtask
  task automatic t_all();
    logic [15:0] w0;
    w0 = n_wake;
    pulse(23'h7fffff);
    rd(iefb_pkg::OFS_PRIMARY_0, 8'h40);
    rd(iefb_pkg::OFS_PRIMARY_1, 8'hf0);
    rd(iefb_pkg::OFS_PRIMARY_2, 8'h40);
    rd(iefb_pkg::OFS_PRIMARY_3, 8'he0);
    rd(iefb_pkg::OFS_GROUP_0, 8'h70);
    rd(iefb_pkg::OFS_GROUP_1, 8'hf0);
    rd(iefb_pkg::OFS_GROUP_2, 8'h70);
    rd(iefb_pkg::OFS_GROUP_3, 8'hf0);
    chk({31'h0, n_wake != w0}, 32'h1);
    for (int a = 4; a <= 6'h20; a += 4) wr(6'(a), 8'h00);
    // flag event lands on the very edge of the clearing write
    fork
      wr(iefb_pkg::OFS_PRIMARY_0, 8'h00);
      begin
        repeat (2) @(posedge sys_clk);
        evt <= 23'h1;
        @(posedge sys_clk);
        evt <= 23'h0;
      end
    join
    rd(iefb_pkg::OFS_PRIMARY_0, 8'h40);
    wr(iefb_pkg::OFS_PRIMARY_0, 8'h00);
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_edges();
    t_vector();
    t_status();
    t_groups();
    t_all();
    end_of_test();
  end
endmodule
